/* hw/adc_seq_pkg.sv */
// Constants and types shared by the power-mode and framing sequencer
package adc_seq_pkg;
	// Serial-clock falling-edge counts within a frame
	localparam int EDGE_CNT_W = 6;
	localparam logic [EDGE_CNT_W-1:0] EDGE_PARTIAL = 6'h02;
	localparam logic [EDGE_CNT_W-1:0] EDGE_AWAKE = 6'h0a;
	localparam logic [EDGE_CNT_W-1:0] EDGE_RESULT = 6'h0e;
	localparam logic [EDGE_CNT_W-1:0] EDGE_SLOT = 6'h10;
	localparam logic [EDGE_CNT_W-1:0] EDGE_DUAL = 6'h20;
	localparam int LEAD_ZEROS = 2;

	// Synchroniser depth for inputs from outside the core clock
	localparam int SYNC_STAGES = 3;

	// Core clock and wake timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int PARTIAL_WAKE_NS = 1000;
	localparam int PARTIAL_RESIDENCY_NS = 67000;
	localparam int DEEP_SLEEP_WAKE_US = 1500;
	localparam int PARTIAL_WAKE_CYC = (PARTIAL_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PARTIAL_RESIDENCY_CYC = (PARTIAL_RESIDENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEEP_SLEEP_WAKE_CYC = (DEEP_SLEEP_WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_W = 17;

	// Threshold event indices crossing from the link domain
	localparam int EV_PARTIAL = 0;
	localparam int EV_AWAKE = 1;
	localparam int EV_RESULT = 2;
	localparam int EV_COUNT = 3;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_PARTIAL,
		MODE_FULL
	} power_mode_type;

	// Mode taken at reset; real silicon powers up in any mode
	localparam power_mode_type MODE_AT_RESET = MODE_NORMAL;
endpackage

/* hw/adc_power_mode_sequencer.sv */
// Power-mode sequencer and serial result framing for a dual sampling converter
// Operation
// - sample inputs and start conversion at chip-select falling edge
// - rise after edge 10, before 14: stay powered, abort, three-state outputs
// - conversion takes 14 clocks; data line keeps driving until chip select rises or edge 32
// - two more clocks low give two trailing zeros after the data
// - further 14 or 16 clocks low give the other result on same line
// - data line three-states at edge 32 or earlier chip-select rise
// - from normal, rise between edges 2 and 10 enters partial power-down
// - from normal, rise before edge 2 keeps normal mode
// - partial power-down keeps only reference and its buffer powered
// - dummy frame wakes; powering continues only when held past edge 10
// - in partial, rise before edge 2 returns to partial, power-up undone
// - in partial, rise between edges 2 and 10 enters full power-down
// - full power-down switches off all analog circuitry and reference
// - frame gives two leading zeros, then 12 bits, last valid at edge 14
// - clock edge coinciding with chip-select fall is not counted
`timescale 1ns/100ps
module adc_power_mode_sequencer
	import adc_seq_pkg::*;
#(
	parameter int RESULT_W = 12,
	parameter int DEEP_WAKE_CYCLES = DEEP_SLEEP_WAKE_CYC,
	parameter bit INTERNAL_REF = 1'b1
) (
	// Core clock and control
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	// Serial link
	input wire logic serialClk,
	input wire logic chipSelectN,
	output logic firstSerialResultLine,
	output logic firstSerialResultLineOe,
	output logic secondSerialResultLine,
	output logic secondSerialResultLineOe,
	// Converter results
	input wire logic [RESULT_W-1:0] resultFirst,
	input wire logic [RESULT_W-1:0] resultSecond,
	// Power and status
	output logic analogPowerOn,
	output logic referencePowerOn,
	output logic powerReady,
	output logic conversionStart,
	output logic conversionAborted,
	output power_mode_type powerMode
);

	// Link domain: frame counter, result shifting, threshold toggles

	logic frameClear;
	logic [EDGE_CNT_W-1:0] edgeCntQ;
	logic [EDGE_CNT_W-1:0] edgeCntD;
	logic [RESULT_W-1:0] capFirstQ;
	logic [RESULT_W-1:0] capSecondQ;
	logic firstBitQ;
	logic secondBitQ;
	// Unpacked so each generate branch owns its own element
	logic evToggleQ [EV_COUNT];

	// Chip select high ends the frame even when the serial clock stops
	assign frameClear = chipSelectN | rst;

	// Counter is held clear while chip select is high, so an edge
	// landing with the fall finds it still in clear
	always_ff @(negedge serialClk or posedge frameClear) begin
		if (frameClear) begin
			edgeCntQ <= '0;
		end else begin
			edgeCntQ <= edgeCntD;
		end
	end

	always_comb begin
		if (edgeCntQ == EDGE_DUAL) begin
			edgeCntD = edgeCntQ;
		end else begin
			edgeCntD = edgeCntQ + 6'h01;
		end
	end

	// Results are captured at the first counted edge of the frame
	always_ff @(negedge serialClk or posedge rst) begin
		if (rst) begin
			capFirstQ <= '0;
			capSecondQ <= '0;
		end else if (!chipSelectN && edgeCntQ == 6'h00) begin
			capFirstQ <= resultFirst;
			capSecondQ <= resultSecond;
		end
	end

	// Bit presented after edge k: two zeros, 12 bits, zeros, then the other result
	function automatic logic slotBit(input logic [EDGE_CNT_W-1:0] k,
		input logic [RESULT_W-1:0] own, input logic [RESULT_W-1:0] other);
		logic [EDGE_CNT_W-1:0] pos;
		logic [RESULT_W-1:0] word;
		int idx;
		pos = (k >= EDGE_SLOT) ? k - EDGE_SLOT : k;
		word = (k >= EDGE_SLOT) ? other : own;
		idx = RESULT_W + LEAD_ZEROS - 1 - int'(pos);
		if (pos < EDGE_CNT_W'(LEAD_ZEROS) || pos >= EDGE_RESULT) begin
			slotBit = 1'b0;
		end else begin
			slotBit = word[idx];
		end
	endfunction

	// First zero shows at the fall itself because the bit registers sit in clear
	always_ff @(negedge serialClk or posedge frameClear) begin
		if (frameClear) begin
			firstBitQ <= 1'b0;
			secondBitQ <= 1'b0;
		end else if (edgeCntD == 6'h01) begin
			firstBitQ <= 1'b0;
			secondBitQ <= 1'b0;
		end else begin
			firstBitQ <= slotBit(edgeCntD, capFirstQ, capSecondQ);
			secondBitQ <= slotBit(edgeCntD, capSecondQ, capFirstQ);
		end
	end

	assign firstSerialResultLine = firstBitQ;
	assign secondSerialResultLine = secondBitQ;
	// Driven from chip-select fall to edge 32 or the rise, whichever first
	assign firstSerialResultLineOe = !chipSelectN && (edgeCntQ < EDGE_DUAL);
	assign secondSerialResultLineOe = !chipSelectN && (edgeCntQ < EDGE_DUAL);

	// One toggle per threshold; levels would vanish with the frame clear
	genvar g;
	for (g = 0; g < EV_COUNT; g++) begin : gen_thresh
		logic [EDGE_CNT_W-1:0] level;
		assign level = (g == EV_PARTIAL) ? EDGE_PARTIAL : (g == EV_AWAKE) ? EDGE_AWAKE : EDGE_RESULT;
		always_ff @(negedge serialClk or posedge rst) begin
			if (rst) begin
				evToggleQ[g] <= 1'b0;
			end else if (!chipSelectN && edgeCntD == level && edgeCntQ != level) begin
				evToggleQ[g] <= ~evToggleQ[g];
			end
		end
	end

	// Core domain: synchronisers

	logic [SYNC_STAGES-1:0] csSyncQ;
	logic csLowQ;
	logic csLowPrevQ;
	logic frameStart;
	logic frameEnd;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csSyncQ <= '1;
		end else if (clkEn) begin
			csSyncQ <= {csSyncQ[SYNC_STAGES-2:0], chipSelectN};
		end
	end

	// Level moves only once the second and third stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			csLowQ <= 1'b0;
			csLowPrevQ <= 1'b0;
		end else if (clkEn) begin
			if (csSyncQ[1] == csSyncQ[2]) begin
				csLowQ <= !csSyncQ[2];
			end
			csLowPrevQ <= csLowQ;
		end
	end

	assign frameStart = csLowQ && !csLowPrevQ;
	assign frameEnd = !csLowQ && csLowPrevQ;

	logic [SYNC_STAGES-1:0] evSyncQ [EV_COUNT];
	logic evSeenQ [EV_COUNT];
	logic evPulse [EV_COUNT];
	logic reachedQ [EV_COUNT];

	for (g = 0; g < EV_COUNT; g++) begin : gen_evsync
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				evSyncQ[g] <= '0;
				evSeenQ[g] <= 1'b0;
			end else if (clkEn) begin
				evSyncQ[g] <= {evSyncQ[g][SYNC_STAGES-2:0], evToggleQ[g]};
				if (evSyncQ[g][1] == evSyncQ[g][2]) begin
					evSeenQ[g] <= evSyncQ[g][2];
				end
			end
		end
		assign evPulse[g] = (evSyncQ[g][1] == evSyncQ[g][2]) && (evSyncQ[g][2] != evSeenQ[g]);

		// Threshold flags clear at frame start; a threshold event wins
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				reachedQ[g] <= 1'b0;
			end else if (clkEn) begin
				if (evPulse[g]) begin
					reachedQ[g] <= 1'b1;
				end else if (frameStart) begin
					reachedQ[g] <= 1'b0;
				end
			end
		end
	end

	// Judge one cycle after the rise so a late threshold event lands first
	logic evalQ;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			evalQ <= 1'b0;
		end else if (clkEn) begin
			evalQ <= frameEnd;
		end
	end

	// Power-mode state

	power_mode_type modeQ;
	power_mode_type modeD;

	always_comb begin
		modeD = modeQ;
		if (reachedQ[EV_AWAKE]) begin
			modeD = MODE_NORMAL;
		end else if (reachedQ[EV_PARTIAL]) begin
			case (modeQ)
				MODE_NORMAL: begin
					modeD = MODE_PARTIAL;
				end
				MODE_PARTIAL: begin
					modeD = MODE_FULL;
				end
				MODE_FULL: begin
					modeD = MODE_FULL;
				end
				default: begin
					modeD = MODE_NORMAL;
				end
			endcase
		end else begin
			modeD = modeQ;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			modeQ <= MODE_AT_RESET;
		end else if (clkEn && evalQ) begin
			modeQ <= modeD;
		end
	end

	// Analog supplies; waking lasts only while the frame is open
	logic waking;
	assign waking = csLowQ && (modeQ != MODE_NORMAL);
	assign analogPowerOn = (modeQ == MODE_NORMAL) || waking;
	assign referencePowerOn = (modeQ != MODE_FULL) || waking;
	assign powerMode = modeQ;

	// Frame events to the converter core
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conversionStart <= 1'b0;
			conversionAborted <= 1'b0;
		end else if (clkEn) begin
			conversionStart <= frameStart;
			conversionAborted <= evalQ && !reachedQ[EV_RESULT];
		end
	end

	// Residency in partial power-down decides how fast the reference wakes
	logic [WAKE_W-1:0] residencyQ;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			residencyQ <= '0;
		end else if (clkEn) begin
			if (modeQ != MODE_PARTIAL) begin
				residencyQ <= '0;
			end else if (residencyQ < WAKE_W'(PARTIAL_RESIDENCY_CYC)) begin
				residencyQ <= residencyQ + 17'h00001;
			end
		end
	end

	// Wake timer runs from the chip-select fall of a waking frame
	logic [WAKE_W-1:0] wakeCntQ;
	logic shortStay;
	assign shortStay = INTERNAL_REF && (residencyQ < WAKE_W'(PARTIAL_RESIDENCY_CYC));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wakeCntQ <= '0;
		end else if (clkEn) begin
			if (frameStart && modeQ == MODE_FULL) begin
				wakeCntQ <= WAKE_W'(DEEP_WAKE_CYCLES);
			end else if (frameStart && modeQ == MODE_PARTIAL) begin
				// Short stay leaves the reference uncharged; assume the slow wake
				wakeCntQ <= shortStay ? WAKE_W'(DEEP_WAKE_CYCLES) : WAKE_W'(PARTIAL_WAKE_CYC);
			end else if (wakeCntQ != '0) begin
				wakeCntQ <= wakeCntQ - 17'h00001;
			end
		end
	end

	// Ready only in normal mode with the wake time spent
	assign powerReady = (modeQ == MODE_NORMAL) && (wakeCntQ == '0);

endmodule

/* testbench/adc_power_mode_sequencer_asserts.sv */
// Concurrent checks for the power-mode sequencer
`timescale 1ns/100ps
module adc_power_mode_sequencer_asserts
	import adc_seq_pkg::*;
(
	// Clocks and link
	input wire logic clk,
	input wire logic rst,
	input wire logic serialClk,
	input wire logic chipSelectN,
	// Watched outputs
	input wire logic firstSerialResultLine,
	input wire logic firstSerialResultLineOe,
	input wire logic secondSerialResultLineOe,
	input wire logic analogPowerOn,
	input wire logic referencePowerOn,
	input wire logic powerReady,
	input wire logic conversionStart,
	input wire power_mode_type powerMode
);
	logic [5:0] falls_q;
	// Own edge count; saturates so long idle-low frames stay quiet
	always_ff @(negedge serialClk or posedge chipSelectN) begin
		if (chipSelectN) begin
			falls_q <= 6'h00;
		end else if (falls_q != 6'h3f) begin
			falls_q <= falls_q + 6'h01;
		end
	end
	AST_OE_OFF: assert property (@(posedge clk) disable iff (rst) chipSelectN |-> !firstSerialResultLineOe)
		else $error("line driven while deselected");
	AST_OE_PAIR: assert property (@(posedge clk) firstSerialResultLineOe == secondSerialResultLineOe)
		else $error("enables differ");
	AST_DRIVE: assert property (@(negedge serialClk) disable iff (rst) falls_q inside {[1:31]} |-> firstSerialResultLineOe)
		else $error("line released early");
	AST_TRISTATE: assert property (@(negedge serialClk) disable iff (rst) falls_q >= 6'h20 |-> !firstSerialResultLineOe)
		else $error("line driven past edge 32");
	AST_LEAD: assert property (@(negedge serialClk) disable iff (rst) !chipSelectN && falls_q <= 6'h01 |-> !firstSerialResultLine)
		else $error("leading bit not zero");
	AST_TRAIL: assert property (@(negedge serialClk) disable iff (rst) falls_q inside {[14:17]} |-> !firstSerialResultLine)
		else $error("trailing bit not zero");
	AST_START: assert property (@(posedge clk) disable iff (rst) $fell(chipSelectN) |-> ##[1:6] conversionStart)
		else $error("no start pulse");
	AST_NORMAL_ON: assert property (@(posedge clk) disable iff (rst) powerMode == MODE_NORMAL |-> analogPowerOn && referencePowerOn)
		else $error("normal mode not powered");
	AST_REF_OFF: assert property (@(posedge clk) disable iff (rst) !referencePowerOn |-> powerMode == MODE_FULL)
		else $error("reference off outside full power-down");
	AST_FULL_FROM: assert property (@(posedge clk) disable iff (rst) $changed(powerMode) && powerMode == MODE_FULL |-> $past(powerMode) == MODE_PARTIAL)
		else $error("full power-down not from partial");
	AST_READY: assert property (@(posedge clk) disable iff (rst) powerReady |-> powerMode == MODE_NORMAL)
		else $error("ready outside normal");
endmodule
bind adc_power_mode_sequencer adc_power_mode_sequencer_asserts u_adc_power_mode_sequencer_asserts (.*);

/* testbench/serial_host_model.sv */
// Host serial port driving chip select and the serial clock
`timescale 1ns/100ps
module serial_host_model (
	// Link toward the device
	output logic serialClk,
	output logic chipSelectN,
	// Result lines read back
	input wire logic lineA,
	input wire logic lineB
);
	logic [31:0] capA;
	logic [31:0] capB;
	// Clock stands high between frames
	// Deferred so the async frame clears see the rise at time zero
	initial begin
		serialClk <= 1'b1;
		chipSelectN <= 1'b1;
	end
	task automatic run(input int falls);
		capA = '0;
		capB = '0;
		#7 chipSelectN = 1'b0;
		for (int k = 0; k < falls; k++) begin
			#32 serialClk = 1'b0;
			#32 serialClk = 1'b1;
			if (k < 32) begin
				capA = {capA[30:0], lineA};
				capB = {capB[30:0], lineB};
			end
		end
		#20 chipSelectN = 1'b1;
		#400;
	endtask
endmodule

/* testbench/adc_power_mode_sequencer_test.sv */
// Self-checking bench for the power-mode sequencer
`timescale 1ns/100ps
module adc_power_mode_sequencer_test;
	import adc_seq_pkg::*;
	logic clk = 1'b0;
	logic rst;
	logic clkEn = 1'b1;
	logic [11:0] resA = 12'h000;
	logic [11:0] resB = 12'h000;
	logic [31:0] mask;
	wire serialClk, chipSelectN, lineA, lineB, anaOn, refOn, ready, abort;
	wire oeA, oeB, start, seenA, seenB;
	power_mode_type mode;
	int failCount = 0;
	int testsRun = 0;
	int aborts = 0;
	int starts = 0;
	int seed = 32'h9414;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (abort === 1'b1) aborts++;
	always @(posedge clk) if (start === 1'b1) starts++;
	// Released lines show the inverse so a sample after release cannot pass
	assign seenA = oeA ? lineA : ~lineA;
	assign seenB = oeB ? lineB : ~lineB;
	adc_power_mode_sequencer #(.DEEP_WAKE_CYCLES(50)) u_adc_power_mode_sequencer (.clk(clk), .rst(rst),
		.clkEn(clkEn), .serialClk(serialClk), .chipSelectN(chipSelectN), .firstSerialResultLine(lineA),
		.firstSerialResultLineOe(oeA), .secondSerialResultLine(lineB), .secondSerialResultLineOe(oeB),
		.resultFirst(resA), .resultSecond(resB), .analogPowerOn(anaOn), .referencePowerOn(refOn),
		.powerReady(ready), .conversionStart(start), .conversionAborted(abort), .powerMode(mode));
	serial_host_model u_serial_host_model (.serialClk(serialClk), .chipSelectN(chipSelectN),
		.lineA(seenA), .lineB(seenB));
	function automatic logic [31:0] frameBits(input logic [11:0] own, input logic [11:0] other);
		return {1'b0, own, 3'b000, 1'b0, other, 3'b000};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		testsRun++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		if (failCount == 0 && testsRun > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic frame(input int falls, input power_mode_type expMode, input int expAborts);
		int a0;
		int s0;
		a0 = aborts;
		s0 = starts;
		@(posedge clk);
		{resB, resA} <= 24'($random(seed));
		@(posedge clk);
		u_serial_host_model.run(falls);
		chk(32'(mode), 32'(expMode), "mode");
		chk(aborts - a0, expAborts, "aborts");
		chk(starts - s0, 1, "starts");
	endtask
	initial begin
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		frame(12, MODE_NORMAL, 1);
		for (int i = 0; i < 6; i++) begin
			frame(i[0] ? 34 : 16, MODE_NORMAL, 0);
			mask = i[0] ? 32'hffff_fffe : 32'hffff_0000;
			chk((u_serial_host_model.capA << (i[0] ? 0 : 16)) & mask, frameBits(resA, resB) & mask, "lineA");
			chk((u_serial_host_model.capB << (i[0] ? 0 : 16)) & mask, frameBits(resB, resA) & mask, "lineB");
			if (i[0]) begin
				chk(u_serial_host_model.capA[0], 1'b1, "lineA release");
			end
		end
		frame(1, MODE_NORMAL, 1);
		frame(5, MODE_PARTIAL, 1);
		chk({anaOn, refOn}, 2'b01, "power");
		frame(1, MODE_PARTIAL, 1);
		chk(anaOn, 1'b0, "analog");
		// Mid-run reset out of partial power-down
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk({anaOn, refOn, ready}, 3'b111, "reset power");
		chk(32'(mode), 32'(MODE_AT_RESET), "reset mode");
		rst <= 1'b0;
		frame(5, MODE_PARTIAL, 1);
		frame(12, MODE_NORMAL, 1);
		frame(5, MODE_PARTIAL, 1);
		frame(9, MODE_FULL, 1);
		chk({anaOn, refOn}, 2'b00, "power");
		frame(3, MODE_FULL, 1);
		frame(10, MODE_NORMAL, 1);
		chk(ready, 1'b0, "early ready");
		@(posedge clk);
		clkEn <= 1'b0;
		repeat (60) @(posedge clk);
		chk(ready, 1'b0, "frozen ready");
		clkEn <= 1'b1;
		for (int n = 0; n < 100 && ready !== 1'b1; n++) @(posedge clk);
		chk(ready, 1'b1, "ready");
		test_done();
	end
endmodule
